// file: hdl/flash_program_erase_protection.sv
// Flash program/erase protection with AXI4-Lite register access
//
// Behaviour
// - Any reset or low-power entry blocks or aborts program and erase.
// - Hardware protection returns control and erase-select registers to reset.
// - With write gate clear, program or erase bits never start an operation.
// - Only selected blocks erase; all-zero selection protects every block.
// - Flash read during an operation sets error flag and aborts.
// - Non-reset exception during an operation sets error flag and aborts.
// - Sleep instruction during an operation sets error flag, error protection.
// - Bus ownership release during an operation sets error flag and aborts.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "flash_prot_consts.svh"
module flash_program_erase_protection
  import flash_prot_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // CPU event pins
  input  wire logic        cpu_flash_read,
  input  wire logic        cpu_exception,
  input  wire logic        cpu_sleep_exec,
  input  wire logic        cpu_bus_release,
  input  wire logic        cpu_low_power,
  input  wire logic        watchdog_reset,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Flash drive
  output logic             program_active,
  output logic             erase_active,
  output logic [15:0]      erase_blocks,
  // Interrupt
  output logic             irq
);
  cpu_events_if ev ();

  logic [7:0]          control_one;
  logic [7:0]          control_two;
  logic [7:0]          erase_block_select_one;
  logic [7:0]          erase_block_select_two;
  logic [`IRQ_WIDTH-1:0] irq_status;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  flash_mode_t         mode;
  logic                error_set;
  logic                hw_protect;
  logic                hw_protect_q;
  logic                flash_write_gate;
  logic                flash_error_flag;

  // Write channel holding
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                wr_fire;
  logic                wr_known;
  logic                rd_known;
  logic [31:0]         rd_word;
  logic                wr_lane0;
  logic [`IRQ_WIDTH-1:0] irq_events;

  event_sync u_sync
  (
    .mclk (mclk),
    .rst_n(rst_n),
    .ce   (ce),
    .raw  ({watchdog_reset, cpu_low_power, cpu_bus_release,
            cpu_sleep_exec, cpu_exception, cpu_flash_read}),
    .ev   (ev)
  );

  // Hardware protection sources
  assign hw_protect = ev.watchdog_reset || ev.low_power;

  assign flash_write_gate = control_one[`BIT_WRITE_GATE];
  assign flash_error_flag = control_two[`BIT_ERROR_FLAG];

  prot_core u_core
  (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .ce         (ce),
    .hw_protect (hw_protect),
    .write_gate (flash_write_gate),
    .program_req(control_one[`BIT_PROGRAM]),
    .erase_req  (control_one[`BIT_ERASE]),
    .erase_sel  ({erase_block_select_two, erase_block_select_one}),
    .ev         (ev),
    .mode       (mode),
    .error_set  (error_set)
  );

  // Register decode
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0 = w_strb[0];
  assign wr_known = (aw_addr == `OFS_CONTROL_ONE) ||
                    (aw_addr == `OFS_CONTROL_TWO) ||
                    (aw_addr == `OFS_ERASE_SEL_ONE) ||
                    (aw_addr == `OFS_ERASE_SEL_TWO) ||
                    (aw_addr == `OFS_IRQ_STATUS) ||
                    (aw_addr == `OFS_IRQ_MASK) ||
                    (aw_addr == `OFS_MODE_STATUS);
  assign rd_known = (s_axi_araddr == `OFS_CONTROL_ONE) ||
                    (s_axi_araddr == `OFS_CONTROL_TWO) ||
                    (s_axi_araddr == `OFS_ERASE_SEL_ONE) ||
                    (s_axi_araddr == `OFS_ERASE_SEL_TWO) ||
                    (s_axi_araddr == `OFS_IRQ_STATUS) ||
                    (s_axi_araddr == `OFS_IRQ_MASK) ||
                    (s_axi_araddr == `OFS_MODE_STATUS);
  assign rd_word =
    (s_axi_araddr == `OFS_CONTROL_ONE)   ? {24'h00_0000, control_one} :
    (s_axi_araddr == `OFS_CONTROL_TWO)   ? {24'h00_0000, control_two} :
    (s_axi_araddr == `OFS_ERASE_SEL_ONE) ?
      {24'h00_0000, erase_block_select_one} :
    (s_axi_araddr == `OFS_ERASE_SEL_TWO) ?
      {24'h00_0000, erase_block_select_two} :
    (s_axi_araddr == `OFS_IRQ_STATUS)    ? {30'h0000_0000, irq_status} :
    (s_axi_araddr == `OFS_IRQ_MASK)      ? {30'h0000_0000, irq_mask} :
    (s_axi_araddr == `OFS_MODE_STATUS)   ? {30'h0000_0000, mode} :
    `RST_WORD;

  assign irq_events[`IRQ_ERROR]    = error_set;
  assign irq_events[`IRQ_HW_ABORT] = hw_protect && !hw_protect_q;

  // Write address and data capture, either order
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= `RST_WORD;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Flash control registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_one            <= `RST_BYTE;
      control_two            <= `RST_BYTE;
      erase_block_select_one <= `RST_BYTE;
      erase_block_select_two <= `RST_BYTE;
    end
    else if (ce)
    begin
      if (hw_protect)
      begin
        control_one            <= `RST_BYTE;
        control_two            <= `RST_BYTE;
        erase_block_select_one <= `RST_BYTE;
        erase_block_select_two <= `RST_BYTE;
      end
      else
      begin
        if (wr_fire && wr_lane0 && aw_addr == `OFS_CONTROL_ONE)
          control_one <= w_data[7:0];
        if (wr_fire && wr_lane0 && aw_addr == `OFS_ERASE_SEL_ONE)
          erase_block_select_one <= w_data[7:0];
        if (wr_fire && wr_lane0 && aw_addr == `OFS_ERASE_SEL_TWO)
          erase_block_select_two <= w_data[7:0];
        if (error_set)
        begin
          control_two[`BIT_ERROR_FLAG] <= 1'b1;
          control_one[`BIT_PROGRAM]    <= 1'b0;
          control_one[`BIT_ERASE]      <= 1'b0;
        end
      end
    end
  end

  // Interrupt status and mask
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status   <= '0;
      irq_mask     <= '0;
      hw_protect_q <= 1'b0;
      irq          <= 1'b0;
    end
    else if (ce)
    begin
      hw_protect_q <= hw_protect;
      if (wr_fire && wr_lane0 && aw_addr == `OFS_IRQ_MASK)
        irq_mask <= w_data[`IRQ_WIDTH-1:0];
      if (wr_fire && wr_lane0 && aw_addr == `OFS_IRQ_STATUS)
        irq_status <= (irq_status & ~w_data[`IRQ_WIDTH-1:0]) | irq_events;
      else
        irq_status <= irq_status | irq_events;
      irq <= |(irq_status & irq_mask);
    end
  end

  // Flash drive outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_active <= 1'b0;
      erase_active   <= 1'b0;
      erase_blocks   <= 16'h0000;
    end
    else if (ce)
    begin
      program_active <= (mode == program_st) && !flash_error_flag;
      erase_active   <= (mode == erase_st) && !flash_error_flag;
      erase_blocks   <= (mode == erase_st) ?
        {erase_block_select_two, erase_block_select_one} : 16'h0000;
    end
  end
endmodule // flash_program_erase_protection
`default_nettype wire

// file: hdl/flash_prot_consts.svh
// Offsets, field positions and reset values of the flash protection block
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH

`define OFS_CONTROL_ONE      8'h00
`define OFS_CONTROL_TWO      8'h04
`define OFS_ERASE_SEL_ONE    8'h08
`define OFS_ERASE_SEL_TWO    8'h0C
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_MASK         8'h14
`define OFS_MODE_STATUS      8'h18

`define BIT_WRITE_GATE       6
`define BIT_ERASE            1
`define BIT_PROGRAM          0
`define BIT_ERROR_FLAG       7

`define RST_BYTE             8'h00
`define RST_WORD             32'h0000_0000

`define IRQ_ERROR            0
`define IRQ_HW_ABORT         1
`define IRQ_WIDTH            2

`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// file: hdl/flash_prot_pkg.sv
// Types of the flash protection block
package flash_prot_pkg;
  typedef enum logic [1:0] {
    idle_st,
    program_st,
    erase_st,
    error_st
  } flash_mode_t;
endpackage

// file: hdl/cpu_events_if.sv
// Synchronised CPU event bundle passed to the protection core
`timescale 1ns/10ps
`default_nettype none
interface cpu_events_if;
  logic flash_read;
  logic exception;
  logic sleep_exec;
  logic bus_release;
  logic low_power;
  logic watchdog_reset;
  modport source (output flash_read, exception, sleep_exec, bus_release,
                  output low_power, watchdog_reset);
  modport sink   (input flash_read, exception, sleep_exec, bus_release,
                  input low_power, watchdog_reset);
endinterface
`default_nettype wire

// file: hdl/event_sync.sv
// Three-stage synchroniser bank for CPU event pins
`timescale 1ns/10ps
`default_nettype none
module event_sync
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Raw pins
  input  wire logic [5:0] raw,
  // Synchronised events
  cpu_events_if.source    ev
);
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] agreed;

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_sync
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1[i]     <= 1'b0;
          s2[i]     <= 1'b0;
          s3[i]     <= 1'b0;
          agreed[i] <= 1'b0;
        end
        else if (ce)
        begin
          s1[i] <= raw[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i])
            agreed[i] <= s3[i];
        end
      end
    end
  endgenerate

  assign ev.flash_read     = agreed[0];
  assign ev.exception      = agreed[1];
  assign ev.sleep_exec     = agreed[2];
  assign ev.bus_release    = agreed[3];
  assign ev.low_power      = agreed[4];
  assign ev.watchdog_reset = agreed[5];
endmodule // event_sync
`default_nettype wire

// file: hdl/prot_core.sv
// Program/erase mode state machine with error protection
`timescale 1ns/10ps
`default_nettype none
module prot_core
  import flash_prot_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Control
  input  wire logic        hw_protect,
  input  wire logic        write_gate,
  input  wire logic        program_req,
  input  wire logic        erase_req,
  input  wire logic [15:0] erase_sel,
  // Events
  cpu_events_if.sink       ev,
  // Status
  output var  flash_mode_t mode,
  output var  logic        error_set
);
  flash_mode_t next_mode;
  logic        in_op;
  logic        fault;

  assign in_op = (mode == program_st) || (mode == erase_st);
  assign fault = in_op && (ev.flash_read || ev.exception ||
                           ev.sleep_exec || ev.bus_release);
  assign error_set = fault;

  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      idle_st:
        if (write_gate && program_req)
          next_mode = program_st;
        else if (write_gate && erase_req && (erase_sel != 16'h0000))
          next_mode = erase_st;
      program_st:
        if (!program_req || !write_gate)
          next_mode = idle_st;
      erase_st:
        if (!erase_req || !write_gate)
          next_mode = idle_st;
      error_st:
        next_mode = error_st;
    endcase
    if (fault)
      next_mode = error_st;
    if (hw_protect)
      next_mode = idle_st;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mode <= idle_st;
    else if (ce)
      mode <= next_mode;
  end
endmodule // prot_core
`default_nettype wire

// file: verification/flash_prot_asserts.sv
// Concurrent checks of the flash protection block ports
`timescale 1ns/10ps
`default_nettype none
module flash_prot_asserts
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // CPU events
  input wire logic        cpu_flash_read,
  input wire logic        cpu_exception,
  input wire logic        cpu_sleep_exec,
  input wire logic        cpu_bus_release,
  input wire logic        cpu_low_power,
  input wire logic        watchdog_reset,
  // Write response
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Flash drive
  input wire logic        program_active,
  input wire logic        erase_active,
  input wire logic [15:0] erase_blocks,
  input wire logic        irq
);
  wire logic busy;
  assign busy = program_active | erase_active;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_hw_abort:
    assert property ((watchdog_reset | cpu_low_power) |-> ##[1:10] !busy)
    else $error("operation live after hardware protection");
  chk_hw_clear:
    assert property ($rose(watchdog_reset) |-> ##[1:10] erase_blocks == 16'h0000)
    else $error("erase blocks kept after hardware protection");
  chk_erase_sel:
    assert property (erase_active |-> erase_blocks != 16'h0000)
    else $error("erase with empty selection");
  chk_read_abort:
    assert property (busy && cpu_flash_read |-> ##[1:10] !busy)
    else $error("flash read did not abort");
  chk_exc_abort:
    assert property (busy && cpu_exception |-> ##[1:10] !busy)
    else $error("exception did not abort");
  chk_sleep_abort:
    assert property (busy && cpu_sleep_exec |-> ##[1:10] !busy)
    else $error("sleep did not abort");
  chk_bus_abort:
    assert property (busy && cpu_bus_release |-> ##[1:10] !busy)
    else $error("bus release did not abort");
  chk_resp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=>
                     s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  cover property ($rose(program_active));
  cover property ($rose(erase_active));
  cover property ($rose(irq));
endmodule // flash_prot_asserts
bind flash_program_erase_protection flash_prot_asserts i_flash_prot_asserts
(
  .mclk, .rst_n, .cpu_flash_read, .cpu_exception, .cpu_sleep_exec,
  .cpu_bus_release, .cpu_low_power, .watchdog_reset, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .program_active, .erase_active,
  .erase_blocks, .irq
);
`default_nettype wire

// file: verification/cpu_event_model.sv
// CPU core model raising event pins for a number of cycles
`timescale 1ns/10ps
`default_nettype none
module cpu_event_model
(
  // Clock
  input  wire logic       mclk,
  // Event pins
  output var  logic [5:0] pins
);
  initial pins = 6'h00;
  task automatic pulse(input int idx, input int len);
    @(posedge mclk);
    pins[idx] <= 1'b1;
    repeat (len) @(posedge mclk);
    pins[idx] <= 1'b0;
  endtask
endmodule // cpu_event_model
`default_nettype wire

// file: verification/flash_program_erase_protection_tb.sv
// Self-checking testbench of the flash protection block
`timescale 1ns/10ps
`default_nettype none
`include "flash_prot_consts.svh"
module flash_program_erase_protection_tb
  import flash_prot_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic        pa, ea, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp;
  logic [15:0] blk, seed;
  logic [5:0]  pins;
  logic [3:0]  ws = 4'hF;
  int          failures = 0;
  int          tests_run = 0;

  flash_program_erase_protection i_flash_program_erase_protection (
    .mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .cpu_flash_read(pins[0]), .cpu_exception(pins[1]),
    .cpu_sleep_exec(pins[2]), .cpu_bus_release(pins[3]),
    .cpu_low_power(pins[4]), .watchdog_reset(pins[5]),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .program_active(pa),
    .erase_active(ea), .erase_blocks(blk), .irq(irq));
  cpu_event_model i_cpu_event_model (.mclk(mclk), .pins(pins));

  always #5 mclk = ~mclk;

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [31:0] blocks_of(input logic [7:0] a, input logic [7:0] b);
    return {16'h0000, b, a};
  endfunction

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    br <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    br <= 1'b0;
    if (n >= 50) failures++;
  endtask

  task rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
            input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge mclk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    rr <= 1'b0;
    if (n >= 50) failures++;
    chk(what, exp, rdat);
    chk("rresp", resp, rresp);
  endtask

  task start_op(input logic prog, input logic [7:0] s1, input logic [7:0] s2);
    wr(`OFS_ERASE_SEL_ONE, s1);
    wr(`OFS_ERASE_SEL_TWO, s2);
    wr(`OFS_CONTROL_ONE, 32'h0000_0040);
    wr(`OFS_CONTROL_ONE, prog ? 32'h0000_0041 : 32'h0000_0042);
    repeat (2) @(posedge mclk);
  endtask

  task final_report;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200_000;
    failures++;
    final_report;
  end

  initial
  begin
    int i;
    {awv, wv, br, arv, rr} = 5'h00;
    {awa, ara, wd} = 48'h0000_0000_0000;
    seed = 16'h0009;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++) rchk("reset", 8'(i * 4), 0, `RESP_OKAY);
    rchk("unmapped", 8'h1C, 0, `RESP_SLVERR);
    wr(8'h1C, 32'h0000_00FF);
    chk("bresp", `RESP_SLVERR, bresp);
    ws <= 4'hE;
    wr(`OFS_CONTROL_ONE, 32'h0000_0040);
    ws <= 4'hF;
    chk("bresp", `RESP_OKAY, bresp);
    rchk("no lane", `OFS_CONTROL_ONE, 0, `RESP_OKAY);
    start_op(1'b1, 8'hFF, 8'h00);
    wr(`OFS_CONTROL_ONE, 32'h0000_0003);
    repeat (3) @(posedge mclk);
    chk("gate clear", 0, {pa, ea});
    start_op(1'b0, 8'h00, 8'h00);
    chk("empty select", 0, ea);
    for (i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      wr(`OFS_IRQ_MASK, 32'(i & 1));
      start_op(i[2], seed[7:0], seed[15:8] | 8'h01);
      chk("mode live", i[2] ? 2 : 1, {pa, ea});
      if (!i[2]) chk("blocks", blocks_of(seed[7:0], seed[15:8] | 8'h01), blk);
      i_cpu_event_model.pulse(i % 4, 2 + seed[1:0]);
      repeat (10) @(posedge mclk);
      chk("abort", 0, {pa, ea});
      wr(`OFS_CONTROL_TWO, 0);
      rchk("error flag", `OFS_CONTROL_TWO, 32'h0000_0080, `RESP_OKAY);
      chk("irq", i & 1, irq);
      wr(`OFS_CONTROL_ONE, 32'h0000_0041);
      repeat (3) @(posedge mclk);
      chk("inhibit", 0, {pa, ea});
      rchk("mode", `OFS_MODE_STATUS, 3, `RESP_OKAY);
      wr(`OFS_IRQ_STATUS, 32'h0000_0003);
      repeat (2) @(posedge mclk);
      chk("irq clear", 0, irq);
      i_cpu_event_model.pulse(i[0] ? 5 : 4, 2);
      repeat (10) @(posedge mclk);
      rchk("reinit", `OFS_CONTROL_TWO, 0, `RESP_OKAY);
      rchk("reinit", `OFS_ERASE_SEL_TWO, 0, `RESP_OKAY);
      start_op(i[1], 8'h01, 8'h00);
      i_cpu_event_model.pulse(i[0] ? 4 : 5, 2);
      repeat (10) @(posedge mclk);
      chk("hw abort", 0, {pa, ea});
      rchk("hw init", `OFS_CONTROL_ONE, 0, `RESP_OKAY);
      rchk("hw init", `OFS_ERASE_SEL_ONE, 0, `RESP_OKAY);
      rchk("hw status", `OFS_IRQ_STATUS, 2, `RESP_OKAY);
    end
    final_report;
  end
endmodule // flash_program_erase_protection_tb
`default_nettype wire
